// ### logic/vpic_pkg.sv
// Package: constants for the vectored priority interrupt controller
package vpic_pkg;
  localparam int NUM_SOURCES  = 32;
  localparam int PRIO_W       = 3;
  localparam int SRC_W        = 5;
  localparam int STACK_DEPTH  = 8;
  localparam int STACK_PTR_W  = 4;
  localparam int VECTOR_W     = 32;
  // Mode register layout: [2:0] priority, [6:5] trigger type
  localparam int MODE_W       = 7;
  localparam int PRIO_LSB     = 0;
  localparam int TRIG_LSB     = 5;
  localparam logic [1:0] TRIG_LEVEL_LOW   = 2'h0;
  localparam logic [1:0] TRIG_EDGE_FALL   = 2'h1;
  localparam logic [1:0] TRIG_LEVEL_HIGH  = 2'h2;
  localparam logic [1:0] TRIG_EDGE_RISE   = 2'h3;
  localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  // Bit set means the source is an external pin with selectable polarity
  localparam logic [31:0] EXTERNAL_SOURCES = 32'hC000_0001;
  localparam logic [VECTOR_W-1:0] VECTOR_RESET = 32'h0000_0000;
endpackage : vpic_pkg

// ### logic/vpic_source_detect.sv
// One source's trigger detection and edge latch
`timescale 1ns/1ps
`default_nettype none
module vpic_source_detect
  import vpic_pkg::*;
#(
  parameter bit EXTERNAL = 1'b0
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Source and mode
  input  wire logic       srcIn,
  input  wire logic [1:0] trigType,
  // Commands
  input  wire logic       setCmd,
  input  wire logic       clearCmd,
  input  wire logic       autoClear,
  // Status
  output logic            pending
);
  logic [1:0] effType;
  logic       isEdge;
  logic       activeHigh;
  logic       level;
  logic       prevLevel_reg;
  logic       prevLevel_next;
  logic       latch_reg;
  logic       latch_next;

  // Internal sources: polarity fixed active high, only level/edge choice
  always_comb begin
    effType = EXTERNAL ? trigType : {1'b1, trigType[0]}; // R2 R3
    isEdge = effType[0]; // R1
    activeHigh = effType[1];
    level = activeHigh ? srcIn : ~srcIn;
  end

  always_comb begin
    prevLevel_next = level;
    latch_next = latch_reg;
    if (!isEdge) begin
      latch_next = 1'b0; // R7
    end else begin
      if (clearCmd || autoClear) begin
        latch_next = 1'b0; // R6 R8
      end
      // Set wins over clear so a coincident edge is not lost
      if (setCmd || (level && !prevLevel_reg)) begin
        latch_next = 1'b1; // R6 R27
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevLevel_reg <= 1'b1;
      latch_reg <= 1'b0;
    end else begin
      prevLevel_reg <= prevLevel_next;
      latch_reg <= latch_next;
    end
  end

  assign pending = isEdge ? latch_reg : level; // R1 R11
endmodule : vpic_source_detect
`default_nettype wire

// ### logic/vpic_nest_stack.sv
// Nesting stack of current interrupt number and level
`timescale 1ns/1ps
`default_nettype none
module vpic_nest_stack
  import vpic_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // Push and pop
  input  wire logic              push,
  input  wire logic [SRC_W-1:0]  pushSrc,
  input  wire logic [PRIO_W-1:0] pushPrio,
  input  wire logic              pop,
  // Top of stack
  output logic                   busy,
  output logic [SRC_W-1:0]       topSrc,
  output logic [PRIO_W-1:0]      topPrio
);
  logic [SRC_W-1:0]       srcMem_reg [STACK_DEPTH];
  logic [PRIO_W-1:0]      prioMem_reg [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] depth_reg;
  logic [STACK_PTR_W-1:0] depth_next;
  logic [2:0]             wrIdx;
  logic [2:0]             topIdx;

  always_comb begin
    depth_next = depth_reg;
    // Overflow drops the push; eight levels cannot nest deeper
    if (push && depth_reg != STACK_PTR_W'(STACK_DEPTH)) begin
      depth_next = depth_reg + 4'h1; // R21 R22
    end else if (pop && depth_reg != 4'h0) begin
      depth_next = depth_reg - 4'h1; // R25
    end
    wrIdx = depth_reg[2:0];
    topIdx = depth_reg[2:0] - 3'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      depth_reg <= 4'h0; // R28
    end else begin
      depth_reg <= depth_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push && depth_reg != STACK_PTR_W'(STACK_DEPTH)) begin
      srcMem_reg[wrIdx] <= pushSrc; // R21
      prioMem_reg[wrIdx] <= pushPrio;
    end
  end

  assign busy = depth_reg != 4'h0;
  assign topSrc = busy ? srcMem_reg[topIdx] : 5'h00;
  assign topPrio = busy ? prioMem_reg[topIdx] : 3'h0;
endmodule : vpic_nest_stack
`default_nettype wire

// ### logic/vectored_priority_interrupt_ctrl.sv
// Top of the vectored eight-level priority interrupt controller
//
// Summary of operation
// R1: Per-source trigger type decides active condition
// R2: Internal sources: level or edge, fixed polarity
// R3: External sources: high, low, rising, falling
// R4: Enable/disable commands set mask, mask readable
// R5: Disabled source excluded, others unaffected
// R6: Set forces edge pending, clear drops latch
// R7: Set/clear ignored for level sources
// R8: Normal vector read clears current edge only
// R9: No auto clear when fast forcing enabled
// R10: Source 0 cleared by fast vector read
// R11: Pending shows activity regardless of mask
// R12: Current source and core request status readable
// R13: Normal request from sources 1..31, unforced
// R14: Three-bit priority, seven highest, zero lowest
// R15: Request immediate; choice made at vector read
// R16: Current level is current source's priority
// R17: Ties go to lowest source number
// R18: While servicing, only higher priority requests
// R19: Software writes end-of-interrupt after servicing
// R20: Higher pending source reasserts normal request
// R21: Vector read pushes number and level
// R22: Stack holds eight nesting entries
// R23: Software re-enables core interrupts and reads vector
// R24: Vector read drops request, returns handler address
// R25: End-of-interrupt pops, restores previous level
// R26: Source 0 fast input, 1 system OR
// R27: Edge latch holds until cleared
// R28: Reset: all disabled, stack empty, requests off
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_ctrl
  import vpic_pkg::*;
#(
  parameter int SYS_LINES = 4
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Interrupt sources
  input  wire logic                   fastInterruptInput,
  input  wire logic [SYS_LINES-1:0]   sysIrqLines,
  input  wire logic [31:2]            periphIrq,
  // Per-source configuration
  input  wire logic [MODE_W-1:0]      sourceModeRegister [NUM_SOURCES],
  input  wire logic [VECTOR_W-1:0]    sourceVectorRegister [NUM_SOURCES],
  input  wire logic [31:0]            fastForceEnable,
  // Command strobes, one cycle each
  input  wire logic                   enableCmdWrite,
  input  wire logic                   disableCmdWrite,
  input  wire logic                   setCmdWrite,
  input  wire logic                   clearCmdWrite,
  input  wire logic [31:0]            cmdData,
  input  wire logic                   normalVectorRead,
  input  wire logic                   fastVectorRead,
  input  wire logic                   endOfInterruptWrite,
  // Status
  output logic [31:0]                 maskRegister,
  output logic [31:0]                 pendingRegister,
  output logic [SRC_W-1:0]            currentSourceRegister,
  output logic [1:0]                  coreStatusRegister,
  output logic [VECTOR_W-1:0]         normalVectorRegister,
  output logic [VECTOR_W-1:0]         fastVectorRegister,
  // Processor core requests
  output logic                        normal_request_out_n,
  output logic                        fast_request_out_n
);
  // ==========================================================================
  // Source inputs and detection
  logic [31:0] srcIn;
  logic [31:0] pending;
  logic [31:0] autoClear;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;

  always_comb begin
    srcIn = {periphIrq, |sysIrqLines, fastInterruptInput}; // R26
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SOURCES; g++) begin : gSrc
      vpic_source_detect #(
        .EXTERNAL (EXTERNAL_SOURCES[g])
      ) uDetect (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .srcIn     (srcIn[g]),
        .trigType  (sourceModeRegister[g][TRIG_LSB +: 2]),
        .setCmd    (setCmdWrite & cmdData[g]),
        .clearCmd  (clearCmdWrite & cmdData[g]),
        .autoClear (autoClear[g]),
        .pending   (pending[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Mask
  always_comb begin
    mask_next = mask_reg;
    if (enableCmdWrite) begin
      mask_next = mask_next | cmdData; // R4
    end
    if (disableCmdWrite) begin
      mask_next = mask_next & ~cmdData; // R4
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= MASK_RESET; // R28
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ==========================================================================
  // Priority arbitration
  logic [31:0]       candidates;
  logic              anyCand;
  logic [SRC_W-1:0]  bestSrc;
  logic [PRIO_W-1:0] bestPrio;
  logic              stackBusy;
  logic [SRC_W-1:0]  curSrc;
  logic [PRIO_W-1:0] curPrio;
  logic              higherWaiting;

  always_comb begin
    // Source 0 and fast-forced sources never reach the normal arbiter
    candidates = pending & mask_reg & ~fastForceEnable & 32'hFFFF_FFFE; // R5 R13
    anyCand = 1'b0;
    bestSrc = 5'h00;
    bestPrio = 3'h0;
    // Scan high to low so the lowest number wins a tie
    for (int i = NUM_SOURCES - 1; i >= 1; i--) begin
      if (candidates[i] &&
          (!anyCand || sourceModeRegister[i][PRIO_LSB +: PRIO_W] >= bestPrio)) begin // R14 R17
        anyCand = 1'b1;
        bestSrc = SRC_W'(i);
        bestPrio = sourceModeRegister[i][PRIO_LSB +: PRIO_W];
      end
    end
    higherWaiting = anyCand && (!stackBusy || bestPrio > curPrio); // R18 R20 R25
  end

  vpic_nest_stack uStack (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .push     (normalVectorRead & anyCand), // R15 R21
    .pushSrc  (bestSrc),
    .pushPrio (bestPrio),
    .pop      (endOfInterruptWrite), // R25
    .busy     (stackBusy),
    .topSrc   (curSrc), // R16
    .topPrio  (curPrio)
  );

  // ==========================================================================
  // Auto clear and request outputs
  logic              normReq_reg;
  logic              normReq_next;
  logic              fastReq_reg;
  logic              fastReq_next;
  logic [VECTOR_W-1:0] nVec_reg;
  logic [VECTOR_W-1:0] nVec_next;
  logic [VECTOR_W-1:0] fVec_reg;
  logic [VECTOR_W-1:0] fVec_next;
  logic              fastSrc;

  always_comb begin
    autoClear = 32'h0000_0000;
    if (normalVectorRead && anyCand && !fastForceEnable[bestSrc]) begin
      autoClear[bestSrc] = 1'b1; // R8 R9
    end
    if (fastVectorRead) begin
      autoClear[0] = 1'b1; // R10
    end
    fastSrc = |(pending & mask_reg & (fastForceEnable | 32'h0000_0001));
    // Vector read drops the request for one cycle; re-evaluated after
    normReq_next = higherWaiting && !normalVectorRead; // R15 R24
    fastReq_next = fastSrc && !fastVectorRead;
    nVec_next = nVec_reg;
    fVec_next = fVec_reg;
    if (normalVectorRead) begin
      nVec_next = anyCand ? sourceVectorRegister[bestSrc] : VECTOR_RESET; // R24
    end
    if (fastVectorRead) begin
      fVec_next = sourceVectorRegister[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      normReq_reg <= 1'b0; // R28
      fastReq_reg <= 1'b0;
      nVec_reg <= VECTOR_RESET;
      fVec_reg <= VECTOR_RESET;
    end else begin
      normReq_reg <= normReq_next;
      fastReq_reg <= fastReq_next;
      nVec_reg <= nVec_next;
      fVec_reg <= fVec_next;
    end
  end

  assign normal_request_out_n = ~normReq_reg;
  assign fast_request_out_n = ~fastReq_reg;
  assign maskRegister = mask_reg; // R4
  assign pendingRegister = pending; // R11
  assign currentSourceRegister = curSrc; // R12
  assign coreStatusRegister = {fastReq_reg, normReq_reg}; // R12
  assign normalVectorRegister = nVec_reg;
  assign fastVectorRegister = fVec_reg;
endmodule : vectored_priority_interrupt_ctrl
`default_nettype wire

// ### bench/vpic_properties.sv
// Port-level assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vpic_checker
  import vpic_pkg::*;
(
  // Clock, reset, inputs
  input wire logic             sys_clk,
  input wire logic             rstn,
  input wire logic [31:0]      fastForceEnable,
  input wire logic             enableCmdWrite,
  input wire logic             disableCmdWrite,
  input wire logic [31:0]      cmdData,
  input wire logic             normalVectorRead,
  // Outputs
  input wire logic [31:0]      maskRegister,
  input wire logic [31:0]      pendingRegister,
  input wire logic [SRC_W-1:0] currentSourceRegister,
  input wire logic [1:0]       coreStatusRegister,
  input wire logic             normal_request_out_n,
  input wire logic             fast_request_out_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ====
  // Properties
  property p_rst; $rose(rstn) |-> maskRegister == 32'h0 && normal_request_out_n && fast_request_out_n; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_stack; $rose(rstn) |-> currentSourceRegister == 5'h00; endproperty
  a_stack: assert property (p_stack) else $error("stack not empty after reset");
  property p_en; enableCmdWrite && !disableCmdWrite |=> (maskRegister & $past(cmdData)) == $past(cmdData); endproperty
  a_en: assert property (p_en) else $error("enable missing from mask");
  property p_dis; disableCmdWrite |=> (maskRegister & $past(cmdData)) == 32'h0; endproperty
  a_dis: assert property (p_dis) else $error("disable missing from mask");
  property p_drop; normalVectorRead |=> normal_request_out_n; endproperty
  a_drop: assert property (p_drop) else $error("request kept after vector read");
  property p_stat; coreStatusRegister == {~fast_request_out_n, ~normal_request_out_n}; endproperty
  a_stat: assert property (p_stat) else $error("core status differs from requests");
  // Request is registered, so it follows last cycle's pending and mask
  property p_norm;
    !normal_request_out_n |-> $past(|(pendingRegister & maskRegister & ~fastForceEnable & 32'hFFFF_FFFE));
  endproperty
  a_norm: assert property (p_norm) else $error("normal request without source");
  property p_fast; !fast_request_out_n |-> $past(pendingRegister[0] && maskRegister[0] || |(pendingRegister & fastForceEnable)); endproperty
  a_fast: assert property (p_fast) else $error("fast request without source");
  c_read: cover property (normalVectorRead && !normal_request_out_n);
  c_nest: cover property (normalVectorRead && currentSourceRegister != 5'h00);
  c_fast: cover property (!fast_request_out_n);
endmodule // vpic_checker
bind vectored_priority_interrupt_ctrl vpic_checker u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .fastForceEnable(fastForceEnable), .enableCmdWrite(enableCmdWrite), .disableCmdWrite(disableCmdWrite),
  .cmdData(cmdData), .normalVectorRead(normalVectorRead), .maskRegister(maskRegister),
  .pendingRegister(pendingRegister), .currentSourceRegister(currentSourceRegister),
  .coreStatusRegister(coreStatusRegister), .normal_request_out_n(normal_request_out_n),
  .fast_request_out_n(fast_request_out_n));
`default_nettype wire

// ### bench/vpic_core_model.sv
// Processor core stand-in: takes vectors and ends service
`timescale 1ns/1ps
`default_nettype none
module vpic_core_model (
  // Requests in
  input  wire logic sys_clk,
  input  wire logic normal_request_out_n,
  input  wire logic fast_request_out_n,
  // Strobes out
  output var logic  normalVectorRead,
  output var logic  fastVectorRead,
  output var logic  endOfInterruptWrite
);
  initial {normalVectorRead, fastVectorRead, endOfInterruptWrite} = 3'h0;
  task automatic take(input bit f, input int lat, output bit ok);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((f ? fast_request_out_n : normal_request_out_n) !== 1'b0 && n < 40);
    ok = n < 40;
    // Slow core: request must still stand when the read lands
    repeat (lat) begin
      @(posedge sys_clk);
      #1;
    end
    {fastVectorRead, normalVectorRead} = f ? 2'h2 : 2'h1;
    @(posedge sys_clk);
    #1;
    {fastVectorRead, normalVectorRead} = 2'h0;
  endtask
  task automatic eoi();
    endOfInterruptWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    endOfInterruptWrite = 1'b0;
  endtask
endmodule // vpic_core_model
`default_nettype wire

// ### bench/test_vectored_priority_interrupt_ctrl.sv
// Self-checking bench for the vectored priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_vectored_priority_interrupt_ctrl
  import vpic_pkg::*;
();
  logic sys_clk = 1'b0, rstn = 1'b0, fastInterruptInput = 1'b0;
  logic [3:0] sysIrqLines = 4'h0, cmdStrobe = 4'h0;
  logic [31:2] periphIrq = 30'h0;
  logic [MODE_W-1:0] sourceModeRegister [NUM_SOURCES];
  logic [VECTOR_W-1:0] sourceVectorRegister [NUM_SOURCES];
  logic [31:0] fastForceEnable = 32'h0, cmdData = 32'h0, m, d;
  wire logic nRd, fRd, eoiWr, nReq, fReq;
  wire logic [31:0] maskReg, pendReg, nVec, fVec;
  wire logic [SRC_W-1:0] curSrc;
  wire logic [1:0] coreStat;
  logic [31:0] expQ [$];
  int n_mismatch = 0, total_checks = 0;
  bit ok;
  always #12.5 sys_clk = ~sys_clk;
  vectored_priority_interrupt_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .fastInterruptInput(fastInterruptInput),
    .sysIrqLines(sysIrqLines), .periphIrq(periphIrq), .sourceModeRegister(sourceModeRegister),
    .sourceVectorRegister(sourceVectorRegister), .fastForceEnable(fastForceEnable), .enableCmdWrite(cmdStrobe[3]),
    .disableCmdWrite(cmdStrobe[2]), .setCmdWrite(cmdStrobe[1]), .clearCmdWrite(cmdStrobe[0]), .cmdData(cmdData),
    .normalVectorRead(nRd), .fastVectorRead(fRd), .endOfInterruptWrite(eoiWr), .maskRegister(maskReg),
    .pendingRegister(pendReg), .currentSourceRegister(curSrc), .coreStatusRegister(coreStat),
    .normalVectorRegister(nVec), .fastVectorRegister(fVec), .normal_request_out_n(nReq), .fast_request_out_n(fReq));
  vpic_core_model u_core (.sys_clk(sys_clk), .normal_request_out_n(nReq), .fast_request_out_n(fReq),
    .normalVectorRead(nRd), .fastVectorRead(fRd), .endOfInterruptWrite(eoiWr));
  function automatic logic [6:0] md(input logic [1:0] t, input logic [2:0] p);
    return {t, 2'h0, p};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Strobe rests one cycle so back-to-back calls never collide
  task automatic cmd(input logic [3:0] s, input logic [31:0] v);
    {cmdStrobe, cmdData} = {s, v};
    tick(1);
    cmdStrobe = 4'h0;
    tick(1);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic irq(input bit f, input int lat, input logic [31:0] v);
    expQ.push_back(v);
    u_core.take(f, lat, ok);
    chk(ok, 32'h1);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ====
  // Vector watcher
  initial begin
    logic f;
    forever begin
      @(posedge sys_clk);
      f = fRd;
      if (f === 1'b1 || nRd === 1'b1) begin
        #2;
        chk(f ? fVec : nVec, expQ.pop_front());
      end
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(52));
    foreach (sourceModeRegister[i]) sourceModeRegister[i] = md(TRIG_LEVEL_HIGH, 3'h0);
    foreach (sourceVectorRegister[i]) sourceVectorRegister[i] = $urandom;
    m = 32'h0;
    tick(3);
    rstn = 1'b1;
    chk(maskReg, 32'h0);
    chk({nReq, fReq, curSrc}, 32'h60);
    repeat (4) begin
      d = $urandom;
      cmd(4'h8, d);
      m = m | d;
      chk(maskReg, m);
      d = $urandom;
      cmd(4'h4, d);
      m = m & ~d;
      chk(maskReg, m);
    end
    cmd(4'h4, 32'hFFFF_FFFF);
    sourceModeRegister[5] = md(TRIG_LEVEL_HIGH, 3'h3);
    {periphIrq[6], periphIrq[5], sysIrqLines} = 6'h34;
    cmd(4'h8, 32'h20);
    cmd(4'h1, 32'h62);
    chk(pendReg & 32'h62, 32'h62);
    chk(nReq, 32'h0);
    irq(0, 0, sourceVectorRegister[5]);
    chk(curSrc, 32'h5);
    tick(3);
    chk(nReq, 32'h1);
    {periphIrq[6], periphIrq[5], sysIrqLines} = 6'h0;
    u_core.eoi();
    chk(curSrc, 32'h0);
    sourceModeRegister[7] = md(TRIG_EDGE_RISE, 3'h4);
    sourceModeRegister[8] = md(TRIG_EDGE_RISE, 3'h2);
    sourceModeRegister[9] = md(TRIG_EDGE_RISE, 3'h4);
    sourceModeRegister[12] = md(TRIG_EDGE_RISE, 3'h6);
    cmd(4'h8, 32'h1380);
    cmd(4'h2, 32'h80);
    cmd(4'h1, 32'h80);
    chk(pendReg & 32'h1380, 32'h0);
    cmd(4'h2, 32'h380);
    irq(0, 2, sourceVectorRegister[7]);
    chk(pendReg & 32'h1380, 32'h300);
    tick(3);
    chk(nReq, 32'h1);
    cmd(4'h2, 32'h1000);
    irq(0, 0, sourceVectorRegister[12]);
    u_core.eoi();
    chk(curSrc, 32'h7);
    tick(2);
    chk(nReq, 32'h1);
    u_core.eoi();
    irq(0, 0, sourceVectorRegister[9]);
    u_core.eoi();
    irq(0, 0, sourceVectorRegister[8]);
    u_core.eoi();
    cmd(4'h8, 32'h0FF0_0000);
    for (int i = 0; i < 8; i++) begin
      sourceModeRegister[20 + i] = md(TRIG_EDGE_RISE, i[2:0]);
      cmd(4'h2, 32'h1 << (20 + i));
      irq(0, 0, sourceVectorRegister[20 + i]);
    end
    for (int i = 7; i >= 0; i--) begin
      chk(curSrc, 20 + i);
      u_core.eoi();
    end
    chk(curSrc, 32'h0);
    cmd(4'h8, 32'h4000_0000);
    for (int t = 0; t < 4; t++) begin
      periphIrq[30] = ~t[1];
      sourceModeRegister[30] = md(t[1:0], 3'h1);
      cmd(4'h1, 32'h4000_0000);
      chk(pendReg[30], 32'h0);
      periphIrq[30] = t[1];
      tick(2);
      chk(pendReg[30], 32'h1);
      periphIrq[30] = ~t[1];
      tick(2);
      chk(pendReg[30], t[0]);
    end
    cmd(4'h4, 32'h4000_0000);
    sourceModeRegister[0] = md(TRIG_EDGE_RISE, 3'h0);
    cmd(4'h8, 32'h1);
    fastInterruptInput = 1'b1;
    tick(3);
    chk({fReq, nReq}, 32'h1);
    irq(1, 1, sourceVectorRegister[0]);
    chk(pendReg[0], 32'h0);
    fastForceEnable = 32'h4;
    sourceModeRegister[2] = md(TRIG_EDGE_RISE, 3'h7);
    cmd(4'h8, 32'h4);
    cmd(4'h2, 32'h4);
    tick(1);
    chk({fReq, nReq}, 32'h1);
    report_and_stop();
  end
endmodule // test_vectored_priority_interrupt_ctrl
`default_nettype wire
